// ### verilog/tfm_monitor.sv
// Transmission fault monitor: speed, range, solenoid and fluid sensor faults
// Contract
// - Store solenoid short code when current >= 1.36 A for 0.5 s.
// - Store solenoid open code when current <= 20 mA for 12.5 s.
// - Twelve output pulses without input pulse count one input failure event.
// - Over 1000 consecutive input events declare temporary input sensor failure.
// - Forty-five input pulses without output pulse count one output failure event.
// - Over 500 consecutive output events declare temporary output sensor failure.
// - Speed failure recurring next ignition cycle sets total 2 and stores code.
// - No range position over 30 s at speed >= 1130 rpm is temporary failure.
// - Two or more range positions over 10 s is temporary failure.
// - Range failure recurring next ignition cycle sets total 2 and stores code.
// - Fluid sensor abnormal 5 min after ignition on is temporary; recurrence stores.
`include "tfm_defs.svh"
module tfm_monitor
  import tfm_pkg::*;
#(
  parameter int RANGE_W = 6,
  parameter int TICK_CYC = `TFM_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic input_shaft_pulse,
  input wire logic output_shaft_pulse,
  input wire logic ignition,
  input wire logic [RANGE_W-1:0] range_selector_switch,
  input wire logic [15:0] line_pressure_solenoid_ma,
  input wire logic [15:0] output_speed_rpm,
  input wire logic transmission_fluid_abnormal,
  output tfm_codes_t temp_fail,
  output tfm_codes_t stored_code
);
  localparam int NF = 6;
  logic [RANGE_W+3:0] raw_in;
  logic [RANGE_W+3:0] sync_in;
  logic in_p;
  logic out_p;
  logic ign;
  logic [RANGE_W-1:0] rng;
  logic fluid_bad;
  logic in_d_reg;
  logic out_d_reg;
  logic ign_d_reg;
  logic in_edge;
  logic out_edge;
  logic ign_on;
  logic tick_reg;
  logic [31:0] div_reg;
  logic [7:0] in_cnt_reg;
  logic [7:0] out_cnt_reg;
  logic [15:0] in_ev_reg;
  logic [15:0] out_ev_reg;
  logic [31:0] short_t_reg;
  logic [31:0] open_t_reg;
  logic [31:0] norng_t_reg;
  logic [31:0] multi_t_reg;
  logic [31:0] temp_t_reg;
  logic [NF-1:0] detect;
  logic [NF-1:0] tmp_reg;
  logic [NF-1:0] seen_reg;
  logic [NF-1:0] code_reg;
  logic [1:0] total_reg [NF];
  logic [2:0] rng_count;
  logic norng_cond;
  logic multi_cond;

  // Pin inputs pass the three-stage synchroniser; readings are already in-domain
  assign raw_in = {transmission_fluid_abnormal, range_selector_switch, ignition,
                   output_shaft_pulse, input_shaft_pulse};
  tfm_sync #(.WIDTH(RANGE_W + 4)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in(raw_in),
    .sync_out(sync_in)
  );
  assign in_p = sync_in[0];
  assign out_p = sync_in[1];
  assign ign = sync_in[2];
  assign rng = sync_in[RANGE_W+2:3];
  assign fluid_bad = sync_in[RANGE_W+3];

  // Edge detection on filtered signals
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      in_d_reg <= 1'b0;
      out_d_reg <= 1'b0;
      ign_d_reg <= 1'b0;
    end else begin
      in_d_reg <= in_p;
      out_d_reg <= out_p;
      ign_d_reg <= ign;
    end
  end
  assign in_edge = in_p & ~in_d_reg;
  assign out_edge = out_p & ~out_d_reg;
  assign ign_on = ign & ~ign_d_reg;

  // Millisecond tick from the system clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else if (div_reg >= 32'(TICK_CYC - 1)) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  // Count of asserted range positions
  always_comb begin
    rng_count = 3'h0;
    for (int i = 0; i < RANGE_W; i++) begin
      rng_count = rng_count + 3'(rng[i]);
    end
  end
  assign norng_cond = (rng_count == 3'h0) && (output_speed_rpm >= `TFM_MIN_RPM);
  assign multi_cond = (rng_count >= 3'h2);

  // Missing input pulse: output pulses counted, any input pulse restarts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      in_cnt_reg <= 8'h0;
      in_ev_reg <= 16'h0;
    end else if (in_edge || ign_on) begin
      in_cnt_reg <= 8'h0;
      in_ev_reg <= 16'h0;
    end else if (out_edge) begin
      if (in_cnt_reg == `TFM_OUT_PULSES - 8'h1) begin
        in_cnt_reg <= 8'h0;
        if (in_ev_reg != 16'hFFFF) begin
          in_ev_reg <= in_ev_reg + 16'h1;
        end
      end else begin
        in_cnt_reg <= in_cnt_reg + 8'h1;
      end
    end
  end

  // Missing output pulse: input pulses counted, any output pulse restarts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_cnt_reg <= 8'h0;
      out_ev_reg <= 16'h0;
    end else if (out_edge || ign_on) begin
      out_cnt_reg <= 8'h0;
      out_ev_reg <= 16'h0;
    end else if (in_edge) begin
      if (out_cnt_reg == `TFM_IN_PULSES - 8'h1) begin
        out_cnt_reg <= 8'h0;
        if (out_ev_reg != 16'hFFFF) begin
          out_ev_reg <= out_ev_reg + 16'h1;
        end
      end else begin
        out_cnt_reg <= out_cnt_reg + 8'h1;
      end
    end
  end

  // Saturating duration timer step, cleared when its condition drops
  function automatic logic [31:0] tmr_step(input logic cond, input logic tick,
                                           input logic [31:0] t);
    if (!cond) begin
      tmr_step = 32'h0;
    end else if (tick && t != 32'hFFFFFFFF) begin
      tmr_step = t + 32'h1;
    end else begin
      tmr_step = t;
    end
  endfunction

  // Duration timers in ms; the fluid timer starts at ignition on
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      short_t_reg <= 32'h0;
      open_t_reg <= 32'h0;
      norng_t_reg <= 32'h0;
      multi_t_reg <= 32'h0;
      temp_t_reg <= 32'h0;
    end else begin
      short_t_reg <= tmr_step(line_pressure_solenoid_ma >= `TFM_SHORT_MA && ign,
                              tick_reg, short_t_reg);
      open_t_reg <= tmr_step(line_pressure_solenoid_ma <= `TFM_OPEN_MA && ign,
                             tick_reg, open_t_reg);
      norng_t_reg <= tmr_step(norng_cond && ign, tick_reg, norng_t_reg);
      multi_t_reg <= tmr_step(multi_cond && ign, tick_reg, multi_t_reg);
      temp_t_reg <= tmr_step(fluid_bad && ign && !ign_on, tick_reg, temp_t_reg);
    end
  end

  // Fault detections, ordered as in the code struct
  assign detect[5] = in_ev_reg > `TFM_IN_EVENTS;
  assign detect[4] = out_ev_reg > `TFM_OUT_EVENTS;
  assign detect[3] = (norng_t_reg > `TFM_NORANGE_MS) ||
                     (multi_t_reg > `TFM_MULTI_MS);
  assign detect[2] = temp_t_reg >= `TFM_TEMP_MS;
  assign detect[1] = short_t_reg >= `TFM_SHORT_MS;
  assign detect[0] = open_t_reg >= `TFM_OPEN_MS;

  // Temporary flags clear at each ignition on; detection wins over clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tmp_reg <= '0;
    end else begin
      tmp_reg <= (ign_on ? '0 : tmp_reg) | detect;
    end
  end

  // Per-cycle totals kept across ignition off; reset only at power-on
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen_reg <= '0;
      code_reg <= '0;
      for (int i = 0; i < NF; i++) begin
        total_reg[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < NF; i++) begin
        if (ign_on) begin
          seen_reg[i] <= 1'b0;
        end else if (detect[i] && !seen_reg[i]) begin
          seen_reg[i] <= 1'b1;
          if (i < 2) begin
            // Solenoid faults store on first detection
            code_reg[i] <= 1'b1;
            total_reg[i] <= 2'h1;
          end else if (total_reg[i] != 2'h0) begin
            total_reg[i] <= `TFM_STORE_TOTAL;
            code_reg[i] <= 1'b1;
          end else begin
            total_reg[i] <= 2'h1;
          end
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      temp_fail <= '0;
      stored_code <= '0;
    end else begin
      temp_fail <= tfm_codes_t'(tmp_reg);
      stored_code <= tfm_codes_t'(code_reg);
    end
  end

  // Solenoid short stores within one to three cycles of the timer reaching its limit
  a_sol_short: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (short_t_reg >= `TFM_SHORT_MS) |-> ##[1:3] stored_code.sol_short)
    else $error("solenoid short code not stored");
  a_sol_open: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (open_t_reg >= `TFM_OPEN_MS) |-> ##[1:3] stored_code.sol_open)
    else $error("solenoid open code not stored");
  a_in_event: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (out_edge && !in_edge && !ign_on && in_cnt_reg == `TFM_OUT_PULSES - 8'h1 &&
     in_ev_reg < 16'hFFFF)
    |=> (in_ev_reg == $past(in_ev_reg) + 16'h1) && in_cnt_reg == 8'h0)
    else $error("missing input event not counted");
  a_out_event: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (in_edge && !out_edge && !ign_on && out_cnt_reg == `TFM_IN_PULSES - 8'h1 &&
     out_ev_reg < 16'hFFFF)
    |=> (out_ev_reg == $past(out_ev_reg) + 16'h1))
    else $error("missing output event not counted");
  a_in_temp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (in_ev_reg == `TFM_IN_EVENTS + 16'h1) |-> ##2 temp_fail.inspd)
    else $error("input sensor temporary failure missing");
  a_out_temp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (out_ev_reg <= `TFM_OUT_EVENTS && $past(out_ev_reg) <= `TFM_OUT_EVENTS && !$past(tmp_reg[4])
     && !$past(ign_on)) |-> !tmp_reg[4])
    else $error("output sensor failure declared early");
  sequence s_repeat_fail(int i);
    detect[i] && !seen_reg[i] && !ign_on && total_reg[i] == 2'h1;
  endsequence
  a_speed_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_repeat_fail(5) |-> ##2 stored_code.inspd)
    else $error("speed code not stored on recurrence");
  a_range_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_repeat_fail(3) |=> total_reg[3] == 2'h2 ##1 stored_code.range)
    else $error("range code not stored on recurrence");
  a_temp_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_repeat_fail(2) |-> ##2 stored_code.temp)
    else $error("fluid code not stored on recurrence");
  a_tmr_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !multi_cond |=> multi_t_reg == 32'h0)
    else $error("range timer not cleared");
  a_ign_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ign_on && detect == '0 |=> tmp_reg == '0 ##1 temp_fail == '0)
    else $error("temporary flags not cleared at ignition on");
  // Below the speed gate the no-position timer must stay idle
  a_norng_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (output_speed_rpm < `TFM_MIN_RPM) |=> norng_t_reg == 32'h0)
    else $error("no-position timer ran below speed gate");
  // An input pulse restarts the missing-input bookkeeping at once
  a_pulse_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_edge |=> in_ev_reg == 16'h0 && in_cnt_reg == 8'h0)
    else $error("missing input count not cleared");
  // Stored codes never drop once set; only power-on reset clears them
  a_code_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (6'(stored_code) & 6'($past(stored_code))) == 6'($past(stored_code)))
    else $error("stored code dropped");
endmodule

// ### include/tfm_defs.svh
// Timing counts and limits for the transmission fault monitor
`ifndef TFM_DEFS_SVH
`define TFM_DEFS_SVH
// Solenoid current limits, milliamps
`define TFM_SHORT_MA 16'h0550
`define TFM_OPEN_MA 16'h0014
// Durations in milliseconds (500, 12500, 30000, 10000, 300000), counted on a 1 ms tick
`define TFM_SHORT_MS 32'h000001F4
`define TFM_OPEN_MS 32'h000030D4
`define TFM_NORANGE_MS 32'h00007530
`define TFM_MULTI_MS 32'h00002710
`define TFM_TEMP_MS 32'h000493E0
// Tick period: 1 ms at 100 MHz
`define TFM_TICK_NS 32'h000F4240
`define TFM_CLK_NS 32'h0000000A
`define TFM_TICK_CYC (`TFM_TICK_NS / `TFM_CLK_NS)
// Pulse counts (12, 45), event limits (1000, 500), speed gate 1130 rpm
`define TFM_OUT_PULSES 8'h0C
`define TFM_IN_PULSES 8'h2D
`define TFM_IN_EVENTS 16'h03E8
`define TFM_OUT_EVENTS 16'h01F4
`define TFM_MIN_RPM 16'h046A
`define TFM_STORE_TOTAL 2'h2
`endif

// ### include/tfm_pkg.sv
// Types of the transmission fault monitor
package tfm_pkg;
  // Fault enumeration, unused; flag vectors put inspd at bit 5 down to sol_open at bit 0
  typedef enum logic [2:0] {
    TFM_F_INSPD = 3'h0,
    TFM_F_OUTSPD = 3'h1,
    TFM_F_RANGE = 3'h2,
    TFM_F_TEMP = 3'h3,
    TFM_F_SOL = 3'h4
  } tfm_fault_t;
  typedef struct packed {
    logic inspd;
    logic outspd;
    logic range;
    logic temp;
    logic sol_short;
    logic sol_open;
  } tfm_codes_t;
endpackage

// ### verilog/tfm_sync.sv
// Three-stage input synchroniser with agreement filter
module tfm_sync
  import tfm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // Stage one feeds only stage two to keep metastability contained
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change is accepted once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// ### testbench/tfm_sensor_model.sv
// Behavioural model of the two shaft speed sensors
module tfm_sensor_model (
  input wire logic clk_sys,
  input wire logic run_in,
  input wire logic run_out,
  output logic input_shaft_pulse,
  output logic output_shaft_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase_reg = 4'h0;
  // One shared phase, so each input pulse has an output pulse beside it
  // Advances on the falling edge so the pins settle well before the design samples
  always @(negedge clk_sys) begin
    phase_reg <= (phase_reg == 4'hB) ? 4'h0 : phase_reg + 4'h1;
  end
  // Six cycles high and six low, above the synchroniser filter
  assign input_shaft_pulse = run_in & (phase_reg < 4'h6);
  // A stopped shaft leaves its sensor line low
  assign output_shaft_pulse = run_out & (phase_reg >= 4'h6);
endmodule

// ### testbench/tfm_monitor_tb_top.sv
// Self-checking testbench for the transmission fault monitor
module tfm_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tfm_pkg::*;
  // One-cycle tick keeps the longest fault times inside the run budget
  localparam int TK = 1;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ignition = 1'b0;
  logic fluid_bad = 1'b0;
  logic run_in = 1'b0;
  logic run_out = 1'b0;
  logic [5:0] range_sel = 6'h01;
  logic [15:0] sol_ma = 16'h01F4;
  logic [15:0] rpm = 16'h0000;
  logic in_p;
  logic out_p;
  tfm_codes_t temp_fail;
  tfm_codes_t stored_code;
  logic [5:0] tf;
  logic [5:0] sc;
  int err_total = 0;
  int checks_done = 0;
  assign tf = temp_fail;
  assign sc = stored_code;

  // Clock, 100 MHz
  always #5 clk_sys = ~clk_sys;

  tfm_monitor #(.RANGE_W(6), .TICK_CYC(TK)) u_dut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .input_shaft_pulse(in_p),
    .output_shaft_pulse(out_p),
    .ignition(ignition),
    .range_selector_switch(range_sel),
    .line_pressure_solenoid_ma(sol_ma),
    .output_speed_rpm(rpm),
    .transmission_fluid_abnormal(fluid_bad),
    .temp_fail(temp_fail),
    .stored_code(stored_code)
  );

  tfm_sensor_model u_sensors (
    .clk_sys(clk_sys),
    .run_in(run_in),
    .run_out(run_out),
    .input_shaft_pulse(in_p),
    .output_shaft_pulse(out_p)
  );

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic run(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Bounded wait for a flag; use_tf picks temp_fail, else stored_code
  task automatic wait_bit(input bit use_tf, input int b, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if ((use_tf ? tf[b] : sc[b]) === 1'b1) begin
        break;
      end
      @(negedge clk_sys);
    end
    chk(i < lim, "flag did not rise in time");
    if (i >= lim) begin
      end_sim();
    end
  endtask

  task automatic ign_cycle();
    ignition = 1'b0;
    run(20);
    ignition = 1'b1;
    run(20);
  endtask

  // Supply short: boundary below limit, interrupted run, then full run
  task automatic t_sol_short();
    sol_ma = 16'h054F;
    run(1200);
    chk(sc[1] === 1'b0, "1359 mA stored a short");
    sol_ma = 16'h0550;
    run(400);
    sol_ma = 16'h01F4;
    run(10);
    sol_ma = 16'h0550;
    run(450);
    chk(sc[1] === 1'b0, "short timer not cleared by gap");
    wait_bit(1'b0, 1, 200);
    run(3);
    chk(tf[1] === 1'b1, "short temp flag missing");
    sol_ma = 16'h01F4;
    $display("test sol_short done");
  endtask

  // Open circuit at exactly the 20 mA limit
  task automatic t_sol_open();
    sol_ma = 16'h0014;
    run(12400);
    chk(sc[0] === 1'b0, "open stored too early");
    wait_bit(1'b0, 0, 400);
    chk(tf[0] === 1'b1, "open temp flag missing");
    sol_ma = 16'h01F4;
    $display("test sol_open done");
  endtask

  // Two positions at once; second ignition cycle must store the code
  task automatic t_range(input logic exp_store);
    range_sel = 6'h05;
    run(9950);
    chk(tf[3] === 1'b0, "range flag before 10 s");
    wait_bit(1'b1, 3, 300);
    run(5);
    chk(sc[3] === exp_store, "range store state wrong");
    range_sel = 6'h01;
    ign_cycle();
    chk(tf[3] === 1'b0, "range flag kept over ignition");
    chk(sc[3] === exp_store, "range code not kept");
    $display("test range done");
  endtask

  // Healthy paired pulse trains must never count a missing-pulse fault
  task automatic t_speed_ok();
    run_in = 1'b1;
    run_out = 1'b1;
    run(3000);
    chk(tf[5] === 1'b0, "input speed fault on good pulses");
    chk(tf[4] === 1'b0, "output speed fault on good pulses");
    run_in = 1'b0;
    run_out = 1'b0;
    $display("test speed_ok done");
  endtask

  // One-sided pulse trains count missing-pulse events; an opposite pulse clears them
  task automatic t_speed_miss();
    run_out = 1'b1;
    run(360);
    chk(u_dut.in_ev_reg === 16'h0002, "missing input events miscounted");
    chk(tf[5] === 1'b0 && sc[5] === 1'b0, "input sensor failure too early");
    run_in = 1'b1;
    run(24);
    chk(u_dut.in_ev_reg === 16'h0000, "input pulse did not clear events");
    run_out = 1'b0;
    run(1200);
    chk(u_dut.out_ev_reg === 16'h0002, "missing output events miscounted");
    chk(tf[4] === 1'b0 && sc[4] === 1'b0, "output sensor failure too early");
    run_in = 1'b0;
    $display("test speed_miss done");
  endtask

  // No position at speed; the slow lead-in proves the speed gate holds the timer
  task automatic t_norange();
    range_sel = 6'h00;
    rpm = 16'h0469;
    run(400);
    rpm = 16'h046A;
    run(29950);
    chk(tf[3] === 1'b0, "no-position flag early or below speed");
    wait_bit(1'b1, 3, 300);
    chk(sc[3] === 1'b1, "range code lost");
    range_sel = 6'h01;
    rpm = 16'h0000;
    $display("test norange done");
  endtask

  // Fluid sensor abnormal well short of the limit, then across an ignition cycle
  task automatic t_fluid();
    fluid_bad = 1'b1;
    run(2000);
    chk(tf[2] === 1'b0 && sc[2] === 1'b0, "fluid fault before 5 min");
    ign_cycle();
    chk(tf[2] === 1'b0 && sc[2] === 1'b0, "fluid fault after ignition cycle");
    chk(tf[3] === 1'b0, "no-position flag kept over ignition");
    fluid_bad = 1'b0;
    $display("test fluid done");
  endtask

  // Main sequence
  initial begin
    run(20);
    rst_b = 1'b1;
    run(2);
    chk(tf === 6'h00 && sc === 6'h00, "outputs not clear after reset");
    ignition = 1'b1;
    run(20);
    t_speed_ok();
    t_speed_miss();
    t_sol_short();
    t_sol_open();
    t_range(1'b0);
    t_range(1'b1);
    t_norange();
    t_fluid();
    end_sim();
  end
endmodule
